// ==== hw/slb_map.vh ====
// constants of the line buffer command and response block
// assumes a 16-bit register port with three address bits
`ifndef SLB_MAP_VH
`define SLB_MAP_VH

// ----------------------------------------------------------------
// register indices on the plain register port
// ----------------------------------------------------------------
`define SLB_REG_TYPE  3'h0
`define SLB_REG_STN   3'h1
`define SLB_REG_ALOW  3'h2
`define SLB_REG_HIGH  3'h3
`define SLB_REG_XCNT  3'h4
`define SLB_REG_CTL   3'h5
`define SLB_REG_STAT  3'h6

// ----------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------
`define SLB_CTL_ASSIGN  0
`define SLB_CTL_HALT    1
`define SLB_CTL_POOL_ON 2
`define SLB_CTL_POOL_OF 3
`define SLB_CTL_POP     4
`define SLB_CTL_EXT     8
`define SLB_CTL_P2P     9

// ----------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------
`define SLB_ST_RSP   0
`define SLB_ST_SCAN  1
`define SLB_ST_BUSY  2
`define SLB_ST_FULL  3
`define SLB_ST_EXT   4
`define SLB_ST_P2P   5

// ----------------------------------------------------------------
// field layout of the type, count and address words
// ----------------------------------------------------------------
`define SLB_F_TYPE 2:0
`define SLB_F_CNT  13:0
`define SLB_F_A18  15:14
`define SLB_F_A22  5:0
`define SLB_F_CODE 7:0

// ----------------------------------------------------------------
// command, disposition and response type codes
// ----------------------------------------------------------------
`define SLB_CMD_RX        3'b000
`define SLB_CMD_TX        3'b100
`define SLB_DSP_RX_DONE   3'b000
`define SLB_DSP_RX_UNUSED 3'b011
`define SLB_DSP_TX_DONE   3'b100
`define SLB_DSP_TX_UNACK  3'b110
`define SLB_DSP_TX_UNSENT 3'b111
`define SLB_TYP_CTRL      3'b001
`define SLB_TYP_INFO      3'b010

// ----------------------------------------------------------------
// control and information codes
// ----------------------------------------------------------------
`define SLB_CODE_TX_THR    8'h04
`define SLB_CODE_POOL_BUSY 8'h5E
`define SLB_CODE_TX_TRIB0  8'h5C
`define SLB_CODE_POOL_DONE 8'h01

// ----------------------------------------------------------------
// line events, table entry kinds, misc values
// ----------------------------------------------------------------
`define SLB_EV_RX_DONE 3'd0
`define SLB_EV_TX_SENT 3'd1
`define SLB_EV_TX_ACK  3'd2
`define SLB_EV_TX_NAK  3'd3
`define SLB_EV_STRT    3'd4
`define SLB_EV_MAINT   3'd5
`define SLB_K_PRIV     2'd0
`define SLB_K_POOL     2'd1
`define SLB_K_TX       2'd2
`define SLB_RETRY_MAX  3'd6
`define SLB_TRIB_POOL  8'h00
`define SLB_TRIB_P2P   8'h01

`endif

// ==== hw/slb_rsp_queue.v ====
// in-order queue of pending responses, flip-flop storage
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps

module slb_rsp_queue #(
  parameter W  = 64,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire          clk,
  input  wire          nrst,
  input  wire          push,
  input  wire [W-1:0]  din,
  output wire          full,
  input  wire          pop,
  output wire [W-1:0]  dout,
  output wire          empty
);

  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire         do_push;
  wire         do_pop;

  // a push into a full queue is dropped, caller must check full
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign full    = (cnt_r == D);
  assign empty   = (cnt_r == {(AW+1){1'b0}});
  assign dout    = mem_r[rp_r];

  // ----------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        mem_r[wp_r] <= din;
        wp_r        <= (wp_r == D-1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (do_pop)
        rp_r <= (rp_r == D-1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (do_push && !do_pop)
        cnt_r <= cnt_r + 1'b1;
      else if (do_pop && !do_push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule // slb_rsp_queue

// ==== hw/slb_ctrl.v ====
// buffer assignment command interpreter and disposition responder
// assumes a line engine that reports events with valid/ready
`timescale 1ns/1ps
`include "slb_map.vh"

module slb_ctrl #(
  parameter N  = 8,
  parameter NW = 3,
  parameter QD = 4,
  parameter QW = 2
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [2:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        ev_valid,
  input  wire [2:0]  ev_kind,
  input  wire [7:0]  ev_trib,
  input  wire [13:0] ev_count,
  output wire        ev_ready,
  output reg         proto_halt,
  output reg  [7:0]  proto_halt_trib
);

  localparam ST_IDLE = 2'd0;
  localparam ST_SCAN = 2'd1;
  localparam ST_DONE = 2'd2;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0]   cmd_type_r;
  reg [7:0]   cmd_stn_r;
  reg [15:0]  cmd_alow_r;
  reg [15:0]  cmd_high_r;
  reg [15:0]  cmd_xcnt_r;
  reg         ext_mode_r;
  reg         p2p_r;
  reg         hc_pend_r;
  reg         hl_pend_r;
  reg [7:0]   hl_trib_r;
  reg [1:0]   st_r;
  reg [NW-1:0] scan_r;
  reg [255:0] pool_en_r;
  reg         ent_v_r    [0:N-1];
  reg [1:0]   ent_k_r    [0:N-1];
  reg         ent_sent_r [0:N-1];
  reg [7:0]   ent_trib_r [0:N-1];
  reg [21:0]  ent_addr_r [0:N-1];
  reg [13:0]  ent_cnt_r  [0:N-1];
  reg [2:0]   ent_try_r  [0:N-1];
  reg         q_push;
  reg [63:0]  q_din;
  wire        q_full;
  wire        q_empty;
  wire [63:0] q_dout;
  wire        q_pop;
  wire [N-1:0] m_free;
  wire [N-1:0] m_priv;
  wire [N-1:0] m_pool;
  wire [N-1:0] m_txu;
  wire [N-1:0] m_txs;
  wire        scan_hit;
  wire        ctl_wr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lowest set bit wins, so in a tie the lowest slot is taken, whatever its age
  function [NW-1:0] first_idx;
    input [N-1:0] v;
    integer i;
    begin
      first_idx = {NW{1'b0}};
      for (i = N-1; i >= 0; i = i - 1)
        if (v[i])
          first_idx = i[NW-1:0];
    end
  endfunction

  function [7:0] stn;
    input [7:0] t;
    begin
      stn = p2p_r ? `SLB_TRIB_P2P : t;
    end
  endfunction

  // disposition word: type, station, low, high, extended count
  function [63:0] disp;
    input [2:0]  code;
    input [7:0]  t;
    input [21:0] a;
    input [13:0] c;
    begin
      if (ext_mode_r)
        disp = {5'h00, code, stn(t), a[15:0], 10'h000, a[21:16], 2'b00, c};
      else
        disp = {5'h00, code, stn(t), a[15:0], a[17:16], c, 16'h0000};
    end
  endfunction

  // control or information word, code in low byte of count word
  function [63:0] ctlrsp;
    input [2:0] typ;
    input [7:0] t;
    input [7:0] code;
    begin
      if (ext_mode_r)
        ctlrsp = {5'h00, typ, stn(t), 16'h0000, 16'h0000, 8'h00, code};
      else
        ctlrsp = {5'h00, typ, stn(t), 16'h0000, 8'h00, code, 16'h0000};
    end
  endfunction

  // ----------------------------------------------------------------
  // per-entry match terms
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_match
      assign m_free[g] = !ent_v_r[g];
      assign m_priv[g] = ent_v_r[g] && ent_k_r[g] == `SLB_K_PRIV && ent_trib_r[g] == ev_trib;
      assign m_pool[g] = ent_v_r[g] && ent_k_r[g] == `SLB_K_POOL;
      assign m_txu[g]  = ent_v_r[g] && ent_k_r[g] == `SLB_K_TX && !ent_sent_r[g]
                         && ent_trib_r[g] == ev_trib;
      assign m_txs[g]  = ent_v_r[g] && ent_k_r[g] == `SLB_K_TX && ent_sent_r[g]
                         && ent_trib_r[g] == ev_trib;
    end
  endgenerate

  // pool return takes pool slots only; keyed on the latched halt tributary
  assign scan_hit = ent_v_r[scan_r] &&
                    ((proto_halt_trib == `SLB_TRIB_POOL) ? (ent_k_r[scan_r] == `SLB_K_POOL)
                     : (ent_k_r[scan_r] != `SLB_K_POOL
                        && ent_trib_r[scan_r] == proto_halt_trib));

  // events drain while a command waits on a full table; maint taken mid-return
  assign ev_ready = (st_r == ST_IDLE) ? (!hl_pend_r && !(hc_pend_r && |m_free) && !q_full)
                    : (st_r == ST_SCAN && ev_kind == `SLB_EV_MAINT && !hl_pend_r);
  assign ctl_wr   = reg_wr && reg_addr == `SLB_REG_CTL;
  assign q_pop    = ctl_wr && reg_wdata[`SLB_CTL_POP];

  // responses leave strictly in push order
  slb_rsp_queue #(
    .W  (64),
    .D  (QD),
    .AW (QW)
  ) u_q (
    .clk   (clk),
    .nrst  (nrst),
    .push  (q_push),
    .din   (q_din),
    .full  (q_full),
    .pop   (q_pop),
    .dout  (q_dout),
    .empty (q_empty)
  );

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // reads of the command offsets show the oldest pending response
  always @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SLB_REG_TYPE: reg_rdata <= q_empty ? 16'h0000 : {8'h00, q_dout[63:56]};
        `SLB_REG_STN:  reg_rdata <= q_empty ? 16'h0000 : {8'h00, q_dout[55:48]};
        `SLB_REG_ALOW: reg_rdata <= q_empty ? 16'h0000 : q_dout[47:32];
        `SLB_REG_HIGH: reg_rdata <= q_empty ? 16'h0000 : q_dout[31:16];
        `SLB_REG_XCNT: reg_rdata <= q_empty ? 16'h0000 : q_dout[15:0];
        `SLB_REG_CTL:  reg_rdata <= {6'h00, p2p_r, ext_mode_r, 8'h00};
        `SLB_REG_STAT: reg_rdata <= {10'h000, p2p_r, ext_mode_r, q_full,
                                     hc_pend_r | hl_pend_r, st_r != ST_IDLE, !q_empty};
        default:       reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // command capture, buffer table and response sequencer
  // ----------------------------------------------------------------
  integer k;
  always @(posedge clk) begin
    if (!nrst) begin
      cmd_type_r      <= 8'h00;
      cmd_stn_r       <= 8'h00;
      cmd_alow_r      <= 16'h0000;
      cmd_high_r      <= 16'h0000;
      cmd_xcnt_r      <= 16'h0000;
      ext_mode_r      <= 1'b0;
      p2p_r           <= 1'b0;
      hc_pend_r       <= 1'b0;
      hl_pend_r       <= 1'b0;
      hl_trib_r       <= 8'h00;
      st_r            <= ST_IDLE;
      scan_r          <= {NW{1'b0}};
      pool_en_r       <= {256{1'b0}};
      proto_halt      <= 1'b0;
      proto_halt_trib <= 8'h00;
      q_push          <= 1'b0;
      q_din           <= 64'h0000_0000_0000_0000;
      for (k = 0; k < N; k = k + 1) begin
        ent_v_r[k]    <= 1'b0;
        ent_sent_r[k] <= 1'b0;
        ent_try_r[k]  <= 3'd0;
      end
    end else begin
      q_push     <= 1'b0;
      proto_halt <= 1'b0;
      // host writes; a command while one is pending is ignored
      if (reg_wr) begin
        case (reg_addr)
          `SLB_REG_TYPE: cmd_type_r <= reg_wdata[7:0];
          `SLB_REG_STN:  cmd_stn_r  <= reg_wdata[7:0];
          `SLB_REG_ALOW: cmd_alow_r <= reg_wdata;
          `SLB_REG_HIGH: cmd_high_r <= reg_wdata;
          `SLB_REG_XCNT: cmd_xcnt_r <= reg_wdata;
          `SLB_REG_CTL: begin
            p2p_r <= reg_wdata[`SLB_CTL_P2P];
            if (reg_wdata[`SLB_CTL_ASSIGN] && !hc_pend_r) begin
              hc_pend_r  <= 1'b1;
              ext_mode_r <= reg_wdata[`SLB_CTL_EXT];
            end
            if (reg_wdata[`SLB_CTL_HALT] && !hl_pend_r) begin
              hl_pend_r <= 1'b1;
              hl_trib_r <= cmd_stn_r;
            end
            if (reg_wdata[`SLB_CTL_POOL_ON])
              pool_en_r[cmd_stn_r] <= 1'b1;
            else if (reg_wdata[`SLB_CTL_POOL_OF])
              pool_en_r[cmd_stn_r] <= 1'b0;
          end
          default: ;
        endcase
      end
      case (st_r)
        ST_IDLE: begin
          if (hl_pend_r && !q_full) begin
            hl_pend_r <= 1'b0;
            if (hl_trib_r == `SLB_TRIB_POOL && |pool_en_r) begin
              q_push <= 1'b1;
              q_din  <= ctlrsp(`SLB_TYP_CTRL, hl_trib_r, `SLB_CODE_POOL_BUSY);
            end else begin
              st_r            <= ST_SCAN;
              scan_r          <= {NW{1'b0}};
              proto_halt      <= 1'b1;
              proto_halt_trib <= hl_trib_r;
            end
          end else if (hc_pend_r && !q_full && |m_free) begin
            if (cmd_type_r[`SLB_F_TYPE] == `SLB_CMD_TX && cmd_stn_r == `SLB_TRIB_POOL) begin
              hc_pend_r <= 1'b0;
              q_push    <= 1'b1;
              q_din     <= ctlrsp(`SLB_TYP_CTRL, cmd_stn_r, `SLB_CODE_TX_TRIB0);
            end else if ((cmd_type_r[`SLB_F_TYPE] == `SLB_CMD_RX
                          || cmd_type_r[`SLB_F_TYPE] == `SLB_CMD_TX) && |m_free) begin
              // one slot per command, unknown type codes are dropped
              hc_pend_r <= 1'b0;
              ent_v_r[first_idx(m_free)]    <= 1'b1;
              ent_sent_r[first_idx(m_free)] <= 1'b0;
              ent_try_r[first_idx(m_free)]  <= 3'd0;
              ent_trib_r[first_idx(m_free)] <= cmd_stn_r;
              ent_k_r[first_idx(m_free)] <= (cmd_type_r[`SLB_F_TYPE] == `SLB_CMD_TX) ? `SLB_K_TX
                : (cmd_stn_r == `SLB_TRIB_POOL) ? `SLB_K_POOL : `SLB_K_PRIV;
              ent_addr_r[first_idx(m_free)] <= ext_mode_r
                ? {cmd_high_r[`SLB_F_A22], cmd_alow_r}
                : {4'h0, cmd_high_r[`SLB_F_A18], cmd_alow_r};
              ent_cnt_r[first_idx(m_free)] <= ext_mode_r ? cmd_xcnt_r[`SLB_F_CNT]
                : cmd_high_r[`SLB_F_CNT];
            end else if (cmd_type_r[`SLB_F_TYPE] != `SLB_CMD_RX
                         && cmd_type_r[`SLB_F_TYPE] != `SLB_CMD_TX) begin
              hc_pend_r <= 1'b0;
            end
          end else if (ev_valid && ev_ready) begin
            case (ev_kind)
              `SLB_EV_RX_DONE: begin
                // private buffers first, pool only for enabled tributaries
                if (|m_priv) begin
                  ent_v_r[first_idx(m_priv)] <= 1'b0;
                  q_push <= 1'b1;
                  q_din  <= disp(`SLB_DSP_RX_DONE, ev_trib,
                                 ent_addr_r[first_idx(m_priv)], ev_count);
                end else if (|m_pool && pool_en_r[ev_trib]) begin
                  ent_v_r[first_idx(m_pool)] <= 1'b0;
                  q_push <= 1'b1;
                  q_din  <= disp(`SLB_DSP_RX_DONE, ev_trib,
                                 ent_addr_r[first_idx(m_pool)], ev_count);
                end
              end
              `SLB_EV_TX_SENT: begin
                if (|m_txu)
                  ent_sent_r[first_idx(m_txu)] <= 1'b1;
              end
              `SLB_EV_TX_ACK: begin
                if (|m_txs) begin
                  ent_v_r[first_idx(m_txs)] <= 1'b0;
                  q_push <= 1'b1;
                  q_din  <= disp(`SLB_DSP_TX_DONE, ev_trib, ent_addr_r[first_idx(m_txs)],
                                 ent_cnt_r[first_idx(m_txs)]);
                end
              end
              `SLB_EV_TX_NAK: begin
                // the buffer stays sent; the engine keeps retrying
                if (|m_txs) begin
                  if (ent_try_r[first_idx(m_txs)] == `SLB_RETRY_MAX) begin
                    ent_try_r[first_idx(m_txs)] <= 3'd0;
                    q_push <= 1'b1;
                    q_din  <= ctlrsp(`SLB_TYP_CTRL, ev_trib, `SLB_CODE_TX_THR);
                  end else begin
                    ent_try_r[first_idx(m_txs)] <= ent_try_r[first_idx(m_txs)] + 3'd1;
                  end
                end
              end
              `SLB_EV_STRT: begin
                hl_pend_r <= 1'b1;
                hl_trib_r <= ev_trib;
              end
              default: ;
            endcase
          end
        end
        ST_SCAN: begin
          // a maintenance message mid-return for another tributary queues a further halt
          if (ev_valid && ev_ready && ev_trib != proto_halt_trib) begin
            hl_pend_r <= 1'b1;
            hl_trib_r <= ev_trib;
          end
          if (!scan_hit || !q_full) begin
            if (scan_hit) begin
              ent_v_r[scan_r] <= 1'b0;
              q_push <= 1'b1;
              q_din  <= disp(ent_k_r[scan_r] != `SLB_K_TX ? `SLB_DSP_RX_UNUSED
                             : ent_sent_r[scan_r] ? `SLB_DSP_TX_UNACK
                             : `SLB_DSP_TX_UNSENT,
                             ent_trib_r[scan_r], ent_addr_r[scan_r], ent_cnt_r[scan_r]);
            end
            scan_r <= scan_r + 1'b1;
            if (scan_r == N-1)
              st_r <= (proto_halt_trib == `SLB_TRIB_POOL) ? ST_DONE : ST_IDLE;
          end
        end
        ST_DONE: begin
          if (!q_full) begin
            q_push <= 1'b1;
            q_din  <= ctlrsp(`SLB_TYP_INFO, `SLB_TRIB_POOL, `SLB_CODE_POOL_DONE);
            st_r   <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

endmodule // slb_ctrl

// ==== verification/slb_ctrl_sva.sv ====
// concurrent checks on the ports of the buffer command block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps

module slb_ctrl_sva #(
  parameter N = 8
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [2:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        ev_valid,
  input wire logic [2:0]  ev_kind,
  input wire logic [7:0]  ev_trib,
  input wire logic [13:0] ev_count,
  input wire logic        ev_ready,
  input wire logic        proto_halt,
  input wire logic [7:0]  proto_halt_trib
);
  // ------------------------------------------------------------
  // shadow of station, mode bits; ext only moves with an assign
  // ------------------------------------------------------------
  logic [7:0] stn_r;
  logic       ext_r;
  logic       p2p_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stn_r <= 8'h00;
      ext_r <= 1'b0;
      p2p_r <= 1'b0;
    end else if (reg_wr && reg_addr == 3'h1) begin
      stn_r <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == 3'h5) begin
      p2p_r <= reg_wdata[9];
      if (reg_wdata[0]) begin
        ext_r <= reg_wdata[8];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_unmapped;
    $past(reg_rd) && $past(reg_addr) == 3'h7 |-> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_type;
    $past(reg_rd) && $past(reg_addr) == 3'h0 |-> reg_rdata[2:0] != 3'b101;
  endproperty
  a_type: assert property (p_type) else $error("bad type code");
  property p_mode;
    $past(reg_rd) && $past(reg_addr) == 3'h5 |-> reg_rdata[9:8] == {p2p_r, ext_r};
  endproperty
  a_mode: assert property (p_mode) else $error("mode bits lost");
  property p_stn;
    $past(reg_rd) && $past(reg_addr) == 3'h1 && p2p_r |-> reg_rdata[7:0] <= 8'h01;
  endproperty
  a_stn: assert property (p_stn) else $error("station not one");
  property p_halt_cmd;
    reg_wr && reg_addr == 3'h5 && reg_wdata[1] && stn_r != 8'h00
      |-> ##[1:3] (proto_halt && proto_halt_trib == stn_r);
  endproperty
  a_halt_cmd: assert property (p_halt_cmd) else $error("host halt missed");
  property p_strt;
    ev_valid && ev_ready && ev_kind == 3'd4 |-> ##[1:3] proto_halt;
  endproperty
  a_strt: assert property (p_strt) else $error("start halt missed");
  property p_pulse;
    proto_halt |=> !proto_halt;
  endproperty
  a_pulse: assert property (p_pulse) else $error("halt pulse long");
  property p_scan;
    proto_halt ##1 (ev_valid && ev_kind != 3'd5) |-> !ev_ready;
  endproperty
  a_scan: assert property (p_scan) else $error("event taken in scan");
endmodule // slb_ctrl_sva

bind slb_ctrl slb_ctrl_sva #(.N(N)) u_sva (.*);

// ==== verification/slb_line_model.sv ====
// line engine model: raises one event per go, holds it until taken
// assumes the same clock and reset as the block
`timescale 1ns/1ps

module slb_line_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [2:0]  kind,
  input  wire logic [7:0]  trib,
  input  wire logic [13:0] cnt,
  output logic             ev_valid,
  output logic [2:0]       ev_kind,
  output logic [7:0]       ev_trib,
  output logic [13:0]      ev_count,
  input  wire logic        ev_ready,
  output logic             done
);
  // ------------------------------------------------------------
  // idle fields show the inverse so stale values never match
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (!nrst) begin
      ev_valid <= 1'b0;
      ev_kind  <= 3'd0;
      ev_trib  <= 8'h00;
      ev_count <= 14'h0000;
    end else if (ev_valid && ev_ready) begin
      ev_valid <= 1'b0;
      done     <= 1'b1;
      ev_kind  <= ~ev_kind;
      ev_trib  <= ~ev_trib;
      ev_count <= ~ev_count;
    end else if (go && !ev_valid) begin
      ev_valid <= 1'b1;
      ev_kind  <= kind;
      ev_trib  <= trib;
      ev_count <= cnt;
    end
  end
endmodule // slb_line_model

// ==== verification/slb_ctrl_tb_top.sv ====
// self-checking bench for the buffer command block
// assumes the line model drives the event link
`timescale 1ns/1ps

module slb_ctrl_tb_top;
  logic        clk, nrst, reg_wr, reg_rd, ev_valid, ev_ready, proto_halt, go, done, p2p;
  logic [2:0]  reg_addr, ev_kind, kind;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0]  ev_trib, trib, proto_halt_trib;
  logic [13:0] ev_count, cnt;
  int          n_errors, total_checks;

  slb_ctrl DUT (.*);
  slb_line_model u_line (.*);

  // ------------------------------------------------------------
  // bus and event helpers
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  // p2p rides on every control write, so keep it in each one
  task automatic ctl(input logic [15:0] b);
    wr(3'h5, b | {6'h00, p2p, 9'h000});
  endtask
  task automatic wt(input logic [15:0] m, w);
    logic [15:0] s;
    for (int i = 0; i < 60; i++) begin
      rd(3'h6, s);
      if ((s & m) === w) return;
    end
    chk("status wait", s & m, w);
    tally_and_finish();
  endtask
  task automatic asg(input logic [2:0] t, input logic [7:0] s,
                     input logic [15:0] lo, hi, xc, input logic x);
    wr(3'h0, {13'h0000, t});
    wr(3'h1, {8'h00, s});
    wr(3'h2, lo);
    wr(3'h3, hi);
    wr(3'h4, xc);
    ctl({7'h00, x, 8'h01});
    wt(16'h0004, 16'h0000);
  endtask
  task automatic rsp(input logic [2:0] t, input logic [7:0] s, input logic [15:0] lo, hi, xc);
    logic [15:0] v;
    wt(16'h0001, 16'h0001);
    rd(3'h0, v);
    chk("type", {13'h0000, v[2:0]}, {13'h0000, t});
    rd(3'h1, v);
    chk("station", {8'h00, v[7:0]}, {8'h00, s});
    rd(3'h2, v);
    chk("addr low", v, lo);
    rd(3'h3, v);
    chk("high word", v, hi);
    rd(3'h4, v);
    chk("ext count", v, xc);
    ctl(16'h0010);
  endtask
  task automatic ev(input logic [2:0] k, input logic [7:0] t, input logic [13:0] c);
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    trib <= t;
    cnt <= c;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 50; i++) begin
      @(negedge clk);
      if (done === 1'b1) return;
    end
    chk("event taken", 16'h0000, 16'h0001);
    tally_and_finish();
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_tx();
    asg(3'b100, 8'h05, 16'h1234, 16'h8040, 16'h0000, 1'b0);
    ev(3'd1, 8'h05, 14'h0000);
    ev(3'd2, 8'h05, 14'h0000);
    rsp(3'b100, 8'h05, 16'h1234, 16'h8040, 16'h0000);
  endtask
  task automatic sc_rx_ext();
    asg(3'b000, 8'h03, 16'h0010, 16'h003F, 16'h0100, 1'b1);
    ev(3'd0, 8'h03, 14'h0020);
    rsp(3'b000, 8'h03, 16'h0010, 16'h003F, 16'h0020);
  endtask
  // event raised during a halt: the scan must hold it off
  task automatic sc_halt();
    asg(3'b000, 8'h04, 16'h0100, 16'h0010, 16'h0000, 1'b0);
    asg(3'b100, 8'h04, 16'h0200, 16'h0008, 16'h0000, 1'b0);
    asg(3'b100, 8'h04, 16'h0300, 16'h4008, 16'h0000, 1'b0);
    ev(3'd1, 8'h04, 14'h0000);
    ctl(16'h0002);
    ev(3'd2, 8'h04, 14'h0000);
    wt(16'h0002, 16'h0000);
    rsp(3'b011, 8'h04, 16'h0100, 16'h0010, 16'h0000);
    rsp(3'b110, 8'h04, 16'h0200, 16'h0008, 16'h0000);
    rsp(3'b111, 8'h04, 16'h0300, 16'h4008, 16'h0000);
  endtask
  task automatic sc_trib0();
    asg(3'b100, 8'h00, 16'h0400, 16'h0001, 16'h0000, 1'b0);
    rsp(3'b001, 8'h00, 16'h0000, 16'h005C, 16'h0000);
  endtask
  task automatic sc_pool();
    wr(3'h1, 16'h0006);
    ctl(16'h0004);
    asg(3'b000, 8'h00, 16'h0500, 16'h0020, 16'h0000, 1'b0);
    ev(3'd0, 8'h06, 14'h0011);
    rsp(3'b000, 8'h06, 16'h0500, 16'h0011, 16'h0000);
    wr(3'h1, 16'h0000);
    ctl(16'h0002);
    rsp(3'b001, 8'h00, 16'h0000, 16'h005E, 16'h0000);
    wr(3'h1, 16'h0006);
    ctl(16'h0008);
    asg(3'b000, 8'h00, 16'h0600, 16'h0030, 16'h0000, 1'b0);
    ctl(16'h0002);
    rsp(3'b011, 8'h00, 16'h0600, 16'h0030, 16'h0000);
    rsp(3'b010, 8'h00, 16'h0000, 16'h0001, 16'h0000);
  endtask
  task automatic sc_thr();
    logic [15:0] v;
    asg(3'b100, 8'h02, 16'h0700, 16'h0004, 16'h0000, 1'b0);
    ev(3'd1, 8'h02, 14'h0000);
    repeat (6) ev(3'd3, 8'h02, 14'h0000);
    rd(3'h6, v);
    chk("early threshold", v & 16'h0001, 16'h0000);
    ev(3'd3, 8'h02, 14'h0000);
    rsp(3'b001, 8'h02, 16'h0000, 16'h0004, 16'h0000);
    ev(3'd2, 8'h02, 14'h0000);
    rsp(3'b100, 8'h02, 16'h0700, 16'h0004, 16'h0000);
  endtask
  task automatic sc_p2p();
    logic [15:0] v;
    p2p = 1'b1;
    ctl(16'h0000);
    rd(3'h5, v);
    chk("control", v, 16'h0200);
    asg(3'b100, 8'h09, 16'h0800, 16'h0002, 16'h0000, 1'b0);
    ev(3'd1, 8'h09, 14'h0000);
    ev(3'd2, 8'h09, 14'h0000);
    rsp(3'b100, 8'h01, 16'h0800, 16'h0002, 16'h0000);
    p2p = 1'b0;
    ctl(16'h0000);
  endtask
  task automatic sc_strt();
    asg(3'b000, 8'h07, 16'h0900, 16'h0040, 16'h0000, 1'b0);
    asg(3'b000, 8'h08, 16'h0A00, 16'h0050, 16'h0000, 1'b0);
    ev(3'd4, 8'h07, 14'h0000);
    ev(3'd5, 8'h08, 14'h0000);
    rsp(3'b011, 8'h07, 16'h0900, 16'h0040, 16'h0000);
    rsp(3'b011, 8'h08, 16'h0A00, 16'h0050, 16'h0000);
  endtask

  // ------------------------------------------------------------
  // clock, reset and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    logic [15:0] v;
    {nrst, reg_wr, reg_rd, go, p2p, reg_addr, kind, trib, cnt, reg_wdata} = '0;
    {n_errors, total_checks} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(3'h6, v);
    chk("status", v, 16'h0000);
    rd(3'h5, v);
    chk("control", v, 16'h0000);
    rd(3'h7, v);
    chk("unmapped", v, 16'h0000);
    sc_tx();
    sc_rx_ext();
    sc_halt();
    sc_trib0();
    sc_pool();
    sc_thr();
    sc_p2p();
    sc_strt();
    tally_and_finish();
  end
endmodule // slb_ctrl_tb_top
